// >>> design/cpcc_pkg.sv
// Shared constants and types for the power-up configuration controller
package cpcc_pkg;
  localparam int DW = 32;
  localparam int AW = 8;
  localparam int IDX_W = 5;
  localparam int PROF_W = 4;
  localparam int NVM_AW = PROF_W + IDX_W;
  localparam int SRC_W = 3;
  localparam int NSRC = 8;
  localparam int RAT_W = 6;
  localparam int PF_W = 3;
  localparam int NIN = 3;
  localparam int FRAC_W = 24;
  localparam int PDIV_W = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Register word indices
  localparam logic [AW-1:0] R_CTRL = 8'h00;
  localparam logic [AW-1:0] R_XLOAD = 8'h01;
  localparam logic [AW-1:0] R_PDIV = 8'h02;
  localparam logic [AW-1:0] R_FBN = 8'h03;
  localparam logic [AW-1:0] R_FBD = 8'h04;
  localparam logic [AW-1:0] R_S0N = 8'h05;
  localparam logic [AW-1:0] R_S0D = 8'h06;
  localparam logic [AW-1:0] R_S1N = 8'h07;
  localparam logic [AW-1:0] R_S1D = 8'h08;
  localparam logic [AW-1:0] R_SS = 8'h09;
  localparam logic [AW-1:0] R_PINFN = 8'h0a;
  localparam logic [AW-1:0] R_OUT0 = 8'h0b;
  localparam logic [AW-1:0] REG_STATUS = 8'h1f;

  ////////////////////////////////////////////////////////////////////////////
  // Codes and limits
  localparam logic [1:0] SRC_XTAL = 2'h0;
  localparam logic [1:0] SRC_CLKIN2 = 2'h1;
  localparam logic [1:0] SRC_CLKIN3 = 2'h2;
  // Spread amount in 0.01 % steps
  localparam logic [7:0] SS_MIN = 8'h0a;
  localparam logic [7:0] SS_MAX = 8'hfa;
  localparam logic [5:0] SS_MOD_BASE = 6'h1e;
  // Crystal load code in 0.5 pF steps above 2.5 pF, top code is 21.5 pF
  localparam logic [5:0] XL_MAX = 6'h26;
  localparam logic [RAT_W-1:0] DIV_MIN = 6'h01;

  typedef enum logic [2:0] {
    ST_BOOT = 3'b000,
    ST_LOAD = 3'b001,
    ST_CHECK = 3'b010,
    ST_HOLD = 3'b011,
    ST_RUN = 3'b100
  } cpcc_state_t;

  typedef enum logic [2:0] {
    PF_NONE = 3'b000,
    PF_OE = 3'b001,
    PF_SS = 3'b010,
    PF_SEL0 = 3'b011,
    PF_SEL1 = 3'b100,
    PF_FSEL = 3'b101,
    PF_ADDR = 3'b110
  } cpcc_pinfn_t;

  typedef struct packed {
    logic [17:0] rsvd;
    logic [PROF_W-1:0] profile;
    logic ss_center;
    logic ss_en;
    logic [NIN-1:0] in_off;
    logic [1:0] src;
    logic by_reg;
    logic reload;
    logic restart;
  } cpcc_ctrl_t;

  typedef struct packed {
    logic [21:0] rsvd;
    logic en;
    logic [SRC_W-1:0] src;
    logic [RAT_W-1:0] ratio;
  } cpcc_outcfg_t;

  typedef struct packed {
    logic [21:0] rsvd;
    logic [1:0] mod;
    logic [7:0] amount;
  } cpcc_sscfg_t;

  typedef struct packed {
    logic [20:0] rsvd;
    logic [PROF_W-1:0] profile;
    logic [1:0] src;
    logic no_input;
    logic isp_hold;
    logic running;
    logic ready;
    logic loading;
  } cpcc_status_t;

  typedef struct packed {
    logic [PDIV_W-1:0] in_div;
    logic [FRAC_W-1:0] fb_num;
    logic [FRAC_W-1:0] fb_den;
    logic [1:0][FRAC_W-1:0] syn_num;
    logic [1:0][FRAC_W-1:0] syn_den;
  } cpcc_plan_t;

  typedef struct packed {
    logic en;
    logic center;
    logic [7:0] amount;
    logic [5:0] mod_khz;
  } cpcc_ss_t;
endpackage

// >>> design/cpcc_nvm_loader.sv
// Copies one profile image from non-volatile memory into the register file
`timescale 1ns/1ps
module cpcc_nvm_loader #(
  parameter int NREG = 17
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_start,
  input wire logic [cpcc_pkg::PROF_W-1:0] i_profile,
  output logic [cpcc_pkg::NVM_AW-1:0] o_nvm_addr,
  output logic o_nvm_rd,
  output logic o_wr,
  output logic [cpcc_pkg::IDX_W-1:0] o_wr_idx,
  output logic o_done
);
  typedef struct packed {
    logic busy;
    logic [cpcc_pkg::PROF_W-1:0] prof;
    logic [cpcc_pkg::IDX_W-1:0] idx;
    logic wr;
    logic [cpcc_pkg::IDX_W-1:0] wr_idx;
    logic done;
  } cpcc_ld_state_t;

  localparam logic [cpcc_pkg::IDX_W-1:0] LAST = cpcc_pkg::IDX_W'(NREG - 1);

  cpcc_ld_state_t s;
  cpcc_ld_state_t next_s;

  ////////////////////////////////////////////////////////////////////////////
  // Memory answers one cycle after the read, so each write trails its read
  always_comb begin
    next_s = s;
    next_s.wr = 1'b0;
    next_s.done = 1'b0;
    if (s.wr) begin
      next_s.done = s.wr_idx == LAST;
    end
    if (i_start) begin
      next_s.busy = 1'b1;
      next_s.prof = i_profile;
      next_s.idx = '0;
    end else if (s.busy) begin
      next_s.wr = 1'b1;
      next_s.wr_idx = s.idx;
      if (s.idx == LAST) begin
        next_s.busy = 1'b0;
      end else begin
        next_s.idx = s.idx + 1'b1;
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      s <= '0;
    end else if (i_ce) begin
      s <= next_s;
    end
  end

  assign o_nvm_addr = {s.prof, s.idx};
  assign o_nvm_rd = s.busy;
  assign o_wr = s.wr;
  assign o_wr_idx = s.wr_idx;
  assign o_done = s.done;
endmodule

// >>> design/cpcc_out_div.sv
// Per-output integer divider whose ratio changes only at a period boundary
`timescale 1ns/1ps
module cpcc_out_div #(
  parameter int W = 6
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_en,
  input wire logic i_tick,
  input wire logic [W-1:0] i_ratio,
  output logic o_clk
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic out;
  } cpcc_div_state_t;

  cpcc_div_state_t s;
  cpcc_div_state_t next_s;
  logic [W-1:0] eff;

  // Ratio zero is not a legal divide, treat it as the lowest one
  assign eff = (i_ratio < cpcc_pkg::DIV_MIN) ? cpcc_pkg::DIV_MIN : i_ratio;

  ////////////////////////////////////////////////////////////////////////////
  // A new ratio is sampled only when a period ends, so no runt pulse appears
  always_comb begin
    next_s = s;
    next_s.out = 1'b0;
    if (!i_en) begin
      next_s.cnt = '0;
    end else if (i_tick) begin
      if (s.cnt == '0) begin
        next_s.out = 1'b1;
        next_s.cnt = eff - 1'b1;
      end else begin
        next_s.cnt = s.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      s <= '0;
    end else if (i_ce) begin
      s <= next_s;
    end
  end

  assign o_clk = s.out;
endmodule

// >>> design/cpcc_top.sv
// Power-up loader, register file and output control of the clock generator
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ps
// Overview of operation
// - After power-up, load register defaults and configuration from NVM first.
// - Serial register access works only after initialization has finished.
// - All clock outputs stay squelched until initialization is done.
// - Stored user configuration becomes the default at every power-up.
// - Programming strap: come up loaded but with every output disabled.
// - In that mode host writes registers, restarts; no NVM reload happens.
// - Two hardware pins may form a two-bit input source selector.
// - Host may select the input source by writing a register.
// - Each hardware pin takes one function: OE, SS, select, freq, address.
// - Input, feedback fraction and synthesis fraction dividers set the plan.
// - Cross-point mux routes two fractional or five integer paths anywhere.
// - Each output integer divider divides by 1 to 63.
// - Crystal load capacitance is set by register from 2.5 to 21.5 pF.
// - Each unused clock input can be switched off by register.
// - Up to 16 stored configuration profiles are selectable.
// - Spread spectrum down or center, 0.1 to 2.5 percent, 30 to 33 kHz.
// - Each output ratio changes on the fly without glitches.
// - A register bit chooses pin or register input selection.
// - No input clock on the selected input at power-up means no outputs.
module cpcc_top #(
  parameter int NOUT = 6,
  parameter int NPIN = 7
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [cpcc_pkg::AW-1:0] i_reg_addr,
  input wire logic [cpcc_pkg::DW-1:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [cpcc_pkg::DW-1:0] o_reg_rdata,
  output logic [cpcc_pkg::NVM_AW-1:0] o_nvm_addr,
  output logic o_nvm_rd,
  input wire logic [cpcc_pkg::DW-1:0] i_nvm_data,
  input wire logic i_otp_isp,
  input wire logic [NPIN-1:0] i_uhip,
  input wire logic [cpcc_pkg::NIN-1:0] i_in_present,
  input wire logic [cpcc_pkg::NSRC-1:0] i_src_tick,
  output logic o_serial_ready,
  output logic o_bus_addr_sel,
  output logic [1:0] o_active_src,
  output logic [cpcc_pkg::NIN-1:0] o_in_power,
  output logic [5:0] o_crystal_load_capacitance,
  output cpcc_pkg::cpcc_plan_t o_plan,
  output cpcc_pkg::cpcc_ss_t o_ss,
  output logic [cpcc_pkg::PROF_W-1:0] o_profile,
  output logic [NOUT-1:0] o_clk_out
);
  localparam int NREG = int'(cpcc_pkg::R_OUT0) + NOUT;
  localparam logic [cpcc_pkg::AW-1:0] NREG_A = cpcc_pkg::AW'(NREG);

  typedef struct packed {
    cpcc_pkg::cpcc_state_t st;
    logic isp_pend;
    logic ld_start;
    logic [cpcc_pkg::DW-1:0] rdata;
    cpcc_pkg::cpcc_plan_t plan;
    cpcc_pkg::cpcc_ss_t ss;
    logic [5:0] xl;
    logic [cpcc_pkg::NIN-1:0] in_power;
    logic [cpcc_pkg::PROF_W-1:0] profile;
    logic [1:0] src;
    logic addr_sel;
    logic [NREG-1:0][cpcc_pkg::DW-1:0] regs;
  } cpcc_top_state_t;

  cpcc_top_state_t s;
  cpcc_top_state_t next_s;

  cpcc_pkg::cpcc_ctrl_t ctrl;
  cpcc_pkg::cpcc_ctrl_t wr_ctrl;
  cpcc_pkg::cpcc_sscfg_t sscfg;
  cpcc_pkg::cpcc_status_t status;
  logic ld_wr;
  logic ld_done;
  logic [cpcc_pkg::IDX_W-1:0] ld_idx;
  logic ready;
  logic running;
  logic bus_wr;
  logic restart;
  logic [NPIN-1:0] m_oe;
  logic [NPIN-1:0] m_ss;
  logic [NPIN-1:0] m_sel0;
  logic [NPIN-1:0] m_sel1;
  logic [NPIN-1:0] m_fsel;
  logic [NPIN-1:0] m_addr;
  logic pin_sel_used;
  logic [1:0] pin_src;
  logic [1:0] src_mux;
  logic [1:0] act_src;
  logic sel_present;
  logic outs_ok;
  logic outs_on;
  cpcc_pkg::cpcc_plan_t plan;
  cpcc_pkg::cpcc_ss_t ss;
  logic [5:0] xl;
  logic [cpcc_pkg::NIN-1:0] in_power;
  logic [cpcc_pkg::PROF_W-1:0] profile;
  logic addr_sel;

  assign ctrl = cpcc_pkg::cpcc_ctrl_t'(s.regs[cpcc_pkg::R_CTRL]);
  assign sscfg = cpcc_pkg::cpcc_sscfg_t'(s.regs[cpcc_pkg::R_SS]);
  assign wr_ctrl = cpcc_pkg::cpcc_ctrl_t'(i_reg_wdata);

  ////////////////////////////////////////////////////////////////////////////
  // Hardware pin function decode
  for (genvar p = 0; p < NPIN; p++) begin : g_pin
    cpcc_pkg::cpcc_pinfn_t fn;
    assign fn = cpcc_pkg::cpcc_pinfn_t'(s.regs[cpcc_pkg::R_PINFN][p*cpcc_pkg::PF_W +: cpcc_pkg::PF_W]);
    assign m_oe[p] = fn == cpcc_pkg::PF_OE;
    assign m_ss[p] = fn == cpcc_pkg::PF_SS;
    assign m_sel0[p] = fn == cpcc_pkg::PF_SEL0;
    assign m_sel1[p] = fn == cpcc_pkg::PF_SEL1;
    assign m_fsel[p] = fn == cpcc_pkg::PF_FSEL;
    assign m_addr[p] = fn == cpcc_pkg::PF_ADDR;
  end

  // Every assigned OE pin must be high; with none assigned outputs are enabled
  assign outs_ok = &(~m_oe | i_uhip);
  assign pin_sel_used = |(m_sel0 | m_sel1);
  assign pin_src = {|(m_sel1 & i_uhip), |(m_sel0 & i_uhip)};
  // Register choice also covers a part with no selector pins assigned
  assign src_mux = (ctrl.by_reg || !pin_sel_used) ? ctrl.src : pin_src;
  // The unused fourth code falls back to the crystal
  assign act_src = (src_mux > cpcc_pkg::SRC_CLKIN3) ? cpcc_pkg::SRC_XTAL : src_mux;
  assign sel_present = i_in_present[act_src];

  ////////////////////////////////////////////////////////////////////////////
  // Register access and power-up sequence
  assign ready = (s.st != cpcc_pkg::ST_BOOT) && (s.st != cpcc_pkg::ST_LOAD);
  assign running = s.st == cpcc_pkg::ST_RUN;
  // Dividers stop at the edge that leaves RUN, so no pulse trails into a reload
  assign outs_on = running && outs_ok && (next_s.st == cpcc_pkg::ST_RUN);
  assign bus_wr = i_reg_wr && ready && (i_reg_addr < NREG_A);
  assign restart = i_reg_wr && ready && (i_reg_addr == cpcc_pkg::R_CTRL) && wr_ctrl.restart;

  always_comb begin
    status = '0;
    status.profile = profile;
    status.src = act_src;
    status.no_input = s.st == cpcc_pkg::ST_CHECK;
    status.isp_hold = s.st == cpcc_pkg::ST_HOLD;
    status.running = running;
    status.ready = ready;
    status.loading = !ready;
  end

  always_comb begin
    next_s = s;
    next_s.ld_start = 1'b0;
    next_s.rdata = '0;
    // Outputs are registered so the analog side sees one settled word per cycle
    next_s.plan = plan;
    next_s.ss = ss;
    next_s.xl = xl;
    next_s.in_power = in_power;
    next_s.profile = profile;
    next_s.src = act_src;
    next_s.addr_sel = addr_sel;
    // Loader and bus never write together: the bus is shut while loading
    if (ld_wr) begin
      next_s.regs[ld_idx] = i_nvm_data;
    end
    if (bus_wr) begin
      next_s.regs[i_reg_addr[cpcc_pkg::IDX_W-1:0]] = i_reg_wdata;
    end
    // Restart and reload are commands, never stored
    next_s.regs[cpcc_pkg::R_CTRL][1:0] = 2'h0;
    if (i_reg_rd && ready) begin
      if (i_reg_addr < NREG_A) begin
        next_s.rdata = s.regs[i_reg_addr[cpcc_pkg::IDX_W-1:0]];
      end else if (i_reg_addr == cpcc_pkg::REG_STATUS) begin
        next_s.rdata = status;
      end
    end
    case (s.st)
      cpcc_pkg::ST_BOOT: begin
        // Strap is sampled once, on the first enabled edge after reset
        next_s.isp_pend = i_otp_isp;
        next_s.ld_start = 1'b1;
        next_s.st = cpcc_pkg::ST_LOAD;
      end
      cpcc_pkg::ST_LOAD: begin
        if (ld_done) begin
          next_s.st = s.isp_pend ? cpcc_pkg::ST_HOLD : cpcc_pkg::ST_CHECK;
        end
      end
      cpcc_pkg::ST_CHECK: begin
        if (sel_present) begin
          next_s.st = cpcc_pkg::ST_RUN;
        end
      end
      cpcc_pkg::ST_HOLD: begin
        // Reload request is ignored so host writes are kept
        if (restart) begin
          next_s.isp_pend = 1'b0;
          next_s.st = cpcc_pkg::ST_CHECK;
        end
      end
      cpcc_pkg::ST_RUN: begin
        if (restart && wr_ctrl.reload) begin
          next_s.ld_start = 1'b1;
          next_s.st = cpcc_pkg::ST_LOAD;
        end else if (restart) begin
          next_s.st = cpcc_pkg::ST_CHECK;
        end
      end
      default: begin
        next_s.st = cpcc_pkg::ST_BOOT;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      s <= '0;
      // Reset outputs show what all-zero registers decode to
      s.ss.amount <= cpcc_pkg::SS_MIN;
      s.ss.mod_khz <= cpcc_pkg::SS_MOD_BASE;
      s.in_power <= '1;
    end else if (i_ce) begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Profile image loader
  cpcc_nvm_loader #(
    .NREG(NREG)
  ) u_loader (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_start(s.ld_start),
    .i_profile(ctrl.profile),
    .o_nvm_addr(o_nvm_addr),
    .o_nvm_rd(o_nvm_rd),
    .o_wr(ld_wr),
    .o_wr_idx(ld_idx),
    .o_done(ld_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Output path: cross-point source pick and glitch-free divider per output
  for (genvar o = 0; o < NOUT; o++) begin : g_out
    cpcc_pkg::cpcc_outcfg_t cfg;
    assign cfg = cpcc_pkg::cpcc_outcfg_t'(s.regs[int'(cpcc_pkg::R_OUT0) + o]);
    cpcc_out_div #(
      .W(cpcc_pkg::RAT_W)
    ) u_div (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_ce(i_ce),
      .i_en(outs_on && cfg.en),
      .i_tick(i_src_tick[cfg.src]),
      .i_ratio(cfg.ratio),
      .o_clk(o_clk_out[o])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration fields handed to the analog side
  always_comb begin
    plan.in_div = s.regs[cpcc_pkg::R_PDIV][cpcc_pkg::PDIV_W-1:0];
    plan.fb_num = s.regs[cpcc_pkg::R_FBN][cpcc_pkg::FRAC_W-1:0];
    plan.fb_den = s.regs[cpcc_pkg::R_FBD][cpcc_pkg::FRAC_W-1:0];
    plan.syn_num[0] = s.regs[cpcc_pkg::R_S0N][cpcc_pkg::FRAC_W-1:0];
    plan.syn_den[0] = s.regs[cpcc_pkg::R_S0D][cpcc_pkg::FRAC_W-1:0];
    plan.syn_num[1] = s.regs[cpcc_pkg::R_S1N][cpcc_pkg::FRAC_W-1:0];
    plan.syn_den[1] = s.regs[cpcc_pkg::R_S1D][cpcc_pkg::FRAC_W-1:0];
  end

  always_comb begin
    ss.en = ctrl.ss_en || |(m_ss & i_uhip);
    ss.center = ctrl.ss_center;
    ss.mod_khz = cpcc_pkg::SS_MOD_BASE + 6'(sscfg.mod);
    if (sscfg.amount < cpcc_pkg::SS_MIN) begin
      ss.amount = cpcc_pkg::SS_MIN;
    end else if (sscfg.amount > cpcc_pkg::SS_MAX) begin
      ss.amount = cpcc_pkg::SS_MAX;
    end else begin
      ss.amount = sscfg.amount;
    end
  end

  // Codes past the top step saturate at the largest capacitance
  assign xl = (s.regs[cpcc_pkg::R_XLOAD][5:0] > cpcc_pkg::XL_MAX) ?
    cpcc_pkg::XL_MAX : s.regs[cpcc_pkg::R_XLOAD][5:0];
  // The selected input is never powered down, whatever the mask says
  assign in_power = ~ctrl.in_off | (cpcc_pkg::NIN'(1) << act_src);
  assign profile = ctrl.profile ^ cpcc_pkg::PROF_W'(|(m_fsel & i_uhip));
  assign addr_sel = |(m_addr & i_uhip);

  ////////////////////////////////////////////////////////////////////////////
  // Registered data outputs; they hold while the clock enable is low
  assign o_plan = s.plan;
  assign o_ss = s.ss;
  assign o_crystal_load_capacitance = s.xl;
  assign o_in_power = s.in_power;
  assign o_profile = s.profile;
  assign o_bus_addr_sel = s.addr_sel;
  assign o_active_src = s.src;
  assign o_serial_ready = ready;
  assign o_reg_rdata = s.rdata;
endmodule

// >>> sim/cpcc_top_props.sv
// Port-level assertions for the power-up configuration controller
`timescale 1ns/1ps
module cpcc_top_props #(
  parameter int NOUT = 6
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_reg_rd,
  input wire logic [cpcc_pkg::DW-1:0] o_reg_rdata,
  input wire logic [cpcc_pkg::NVM_AW-1:0] o_nvm_addr,
  input wire logic o_nvm_rd,
  input wire logic [cpcc_pkg::NSRC-1:0] i_src_tick,
  input wire logic o_serial_ready,
  input wire logic [1:0] o_active_src,
  input wire logic [cpcc_pkg::NIN-1:0] o_in_power,
  input wire logic [5:0] o_crystal_load_capacitance,
  input wire cpcc_pkg::cpcc_ss_t o_ss,
  input wire logic [NOUT-1:0] o_clk_out
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  // Frozen cycles hold state, so they are not judged
  default disable iff (i_rst || !i_ce);
  ////////////////////////////////////////
  sequence s_ld_first;
    $rose(o_nvm_rd) && o_nvm_addr[4:0] == 5'h00;
  endsequence
  sequence s_ld_last;
    o_nvm_rd && o_nvm_addr[4:0] == 5'h10 ##1 !o_nvm_rd;
  endsequence
  property p_ld_len;
    s_ld_first |-> ##16 s_ld_last;
  endproperty
  a_ld_len: assert property (p_ld_len) else $error("load length wrong");
  property p_ld_step;
    o_nvm_rd && $past(o_nvm_rd) |-> o_nvm_addr == $past(o_nvm_addr) + 9'h001;
  endproperty
  a_ld_step: assert property (p_ld_step) else $error("load address skipped");
  property p_squelch;
    !o_serial_ready |-> o_clk_out == '0;
  endproperty
  a_squelch: assert property (p_squelch) else $error("output before init done");
  property p_rd_refused;
    !o_serial_ready && i_reg_rd |=> o_reg_rdata == '0;
  endproperty
  a_rd_refused: assert property (p_rd_refused) else $error("read answered during init");
  property p_rd_stands;
    !i_reg_rd |=> o_reg_rdata == '0;
  endproperty
  a_rd_stands: assert property (p_rd_stands) else $error("read data without read");
  property p_xl_max;
    o_crystal_load_capacitance <= 6'h26;
  endproperty
  a_xl_max: assert property (p_xl_max) else $error("load code above top");
  property p_ss_range;
    o_ss.amount inside {[8'h0a:8'hfa]} && o_ss.mod_khz inside {[6'h1e:6'h21]};
  endproperty
  a_ss_range: assert property (p_ss_range) else $error("spread out of range");
  property p_sel_power;
    o_in_power[o_active_src];
  endproperty
  a_sel_power: assert property (p_sel_power) else $error("selected input off");
  property p_pulse_cause;
    o_clk_out != '0 |-> $past(i_src_tick) != '0;
  endproperty
  a_pulse_cause: assert property (p_pulse_cause) else $error("pulse without tick");
endmodule
bind cpcc_top cpcc_top_props #(.NOUT(NOUT)) u_props (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_ce(i_ce),
  .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .o_nvm_addr(o_nvm_addr), .o_nvm_rd(o_nvm_rd),
  .i_src_tick(i_src_tick), .o_serial_ready(o_serial_ready), .o_active_src(o_active_src),
  .o_in_power(o_in_power), .o_crystal_load_capacitance(o_crystal_load_capacitance), .o_ss(o_ss),
  .o_clk_out(o_clk_out));

// >>> sim/cpcc_nvm_model.sv
// Behavioural non-volatile memory answering the loader's word reads
`timescale 1ns/1ps
module cpcc_nvm_model (
  input wire logic i_ref_clk,
  input wire logic i_rd,
  input wire logic [cpcc_pkg::NVM_AW-1:0] i_addr,
  output logic [cpcc_pkg::DW-1:0] o_data
);
  logic [cpcc_pkg::DW-1:0] mem [512];
  int n_rd;
  initial begin
    o_data = '0;
    n_rd = 0;
  end
  // Word one cycle after each request; between reads the data toggles so stale use shows
  always @(posedge i_ref_clk) begin
    if (i_rd) begin
      o_data <= mem[i_addr];
      n_rd <= n_rd + 1;
    end else begin
      o_data <= ~o_data;
    end
  end
endmodule

// >>> sim/test_cpcc_top.sv
// Self-checking bench for the power-up configuration controller
`timescale 1ns/1ps
module test_cpcc_top;
  logic i_ref_clk, i_rst, i_reg_wr, i_reg_rd, i_otp_isp, o_nvm_rd, o_serial_ready, o_bus_addr_sel, cnt_on;
  logic [7:0] i_reg_addr, i_src_tick;
  logic [31:0] i_reg_wdata, o_reg_rdata, i_nvm_data;
  logic [8:0] o_nvm_addr;
  logic [6:0] i_uhip;
  logic [2:0] i_in_present, o_in_power;
  logic [1:0] o_active_src;
  logic [5:0] o_crystal_load_capacitance, o_clk_out;
  logic [3:0] o_profile;
  cpcc_pkg::cpcc_plan_t o_plan;
  cpcc_pkg::cpcc_ss_t o_ss;
  logic [31:0] rm [17];
  int n_errors, tests_run, cyc, k, tc [8], pc [6];
  cpcc_top dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_ce(1'b1), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
    .o_nvm_addr(o_nvm_addr), .o_nvm_rd(o_nvm_rd), .i_nvm_data(i_nvm_data), .i_otp_isp(i_otp_isp),
    .i_uhip(i_uhip), .i_in_present(i_in_present), .i_src_tick(i_src_tick), .o_serial_ready(o_serial_ready),
    .o_bus_addr_sel(o_bus_addr_sel), .o_active_src(o_active_src), .o_in_power(o_in_power),
    .o_crystal_load_capacitance(o_crystal_load_capacitance), .o_plan(o_plan), .o_ss(o_ss),
    .o_profile(o_profile), .o_clk_out(o_clk_out));
  cpcc_nvm_model nvm (.i_ref_clk(i_ref_clk), .i_rd(o_nvm_rd), .i_addr(o_nvm_addr), .o_data(i_nvm_data));
  initial begin
    i_ref_clk = 1'b0;
    forever #4 i_ref_clk = ~i_ref_clk;
  end
  ////////////////////////////////////////
  task automatic conclude;
    $display("Checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Counts ticks per source and pulses per output for the divider model
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cnt_on) begin
      for (int s = 0; s < 8; s++) tc[s] += i_src_tick[s];
      for (int n = 0; n < 6; n++) pc[n] += o_clk_out[n];
    end
    if (cyc == 40000) begin
      n_errors++;
      conclude();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_ref_clk);
    i_reg_wr <= 1'b0;
    if (a < 17) rm[a] = (a == 0) ? (d & 32'hffff_fffc) : d;
    // Data outputs are registered one edge after the register itself
    @(posedge i_ref_clk);
    #1;
  endtask
  task automatic rdv(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_ref_clk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_ref_clk);
    i_reg_rd <= 1'b0;
    #1 d = o_reg_rdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rdv(a, d);
    chk(d, e);
  endtask
  // Polls the status word until the running flag shows, so no tick is lost in between
  task automatic wait_run;
    logic [31:0] d;
    d = '0;
    for (int i = 0; i < 60 && d[2] !== 1'b1; i++) rdv(cpcc_pkg::REG_STATUS, d);
  endtask
  task automatic boot(input logic isp, input logic [2:0] pres);
    @(posedge i_ref_clk);
    i_rst <= 1'b1;
    i_otp_isp <= isp;
    i_in_present <= pres;
    i_uhip <= '0;
    repeat (5) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    for (int i = 0; i < 17; i++) rm[i] = nvm.mem[i];
  endtask
  task automatic run(input int n, input logic ok);
    int r;
    int s;
    tc = '{default: 0};
    pc = '{default: 0};
    cnt_on = 1'b1;
    repeat (n) @(posedge i_ref_clk) i_src_tick <= 8'($urandom);
    @(posedge i_ref_clk) i_src_tick <= '0;
    repeat (3) @(posedge i_ref_clk);
    cnt_on = 1'b0;
    for (int j = 0; j < 6; j++) begin
      r = (rm[11+j][5:0] == 6'h00) ? 1 : int'(rm[11+j][5:0]);
      s = int'(rm[11+j][8:6]);
      chk(pc[j], (ok && rm[11+j][9]) ? (tc[s] + r - 1) / r : 0);
    end
  endtask
  ////////////////////////////////////////
  initial begin
    i_rst = 1'b1;
    i_reg_wr = 1'b0;
    i_reg_rd = 1'b0;
    i_reg_addr = '0;
    i_reg_wdata = '0;
    i_otp_isp = 1'b0;
    i_uhip = '0;
    i_in_present = 3'h7;
    i_src_tick = '0;
    cnt_on = 1'b0;
    for (int a = 0; a < 512; a++) begin
      case (a % 32)
        0: nvm.mem[a] = 32'h0000_0004 | (32'(a / 32) << 10);
        10: nvm.mem[a] = '0;
        11, 12, 13, 14, 15, 16: nvm.mem[a] = 32'h200 | (32'(a % 32 - 11) << 6) | 32'(a % 32 - 10);
        default: nvm.mem[a] = {7'h2d, 9'(a), 7'h00, 9'(a)};
      endcase
    end
    void'($urandom(62));
    boot(1'b0, 3'h7);
    rdc(8'h01, '0);
    wait_run();
    for (int i = 0; i < 17; i++) rdc(8'(i), rm[i]);
    wr(8'h14, $urandom);
    rdc(8'h14, '0);
    chk(o_plan.in_div, rm[2][7:0]);
    chk(o_plan.fb_den, rm[4][23:0]);
    chk(o_plan.syn_num[1], rm[7][23:0]);
    chk(o_crystal_load_capacitance, rm[1][5:0]);
    chk(o_ss.amount, 8'h0a);
    run(200, 1'b1);
    wr(8'h09, 32'h0000_02ff);
    chk({o_ss.amount, o_ss.mod_khz}, {8'hfa, 6'h20});
    wr(8'h09, 32'h0000_0305);
    chk({o_ss.amount, o_ss.mod_khz}, {8'h0a, 6'h21});
    wr(8'h01, 32'h0000_003f);
    chk(o_crystal_load_capacitance, 6'h26);
    wr(8'h00, 32'h0000_02ec);
    chk({o_active_src, o_in_power, o_ss.en, o_ss.center}, {2'h1, 3'h2, 1'b0, 1'b1});
    wr(8'h0a, 32'h0000_01a3);
    wr(8'h00, 32'h0000_0008);
    for (int u = 0; u < 8; u++) begin
      @(posedge i_ref_clk) i_uhip <= 7'(u);
      repeat (2) @(posedge i_ref_clk);
      #1 chk({o_active_src, o_bus_addr_sel}, {(u % 4 == 3) ? 2'h0 : 2'(u % 4), 1'(u / 4)});
    end
    // Pin 3 output enable held low, pin 4 spread enable and pin 5 profile select high
    wr(8'h0a, 32'h0002_a3a3);
    @(posedge i_ref_clk) i_uhip <= 7'h30;
    repeat (2) @(posedge i_ref_clk);
    #1 chk({o_ss.en, o_ss.center, o_profile, o_bus_addr_sel}, {1'b1, 1'b0, 4'h1, 1'b0});
    run(40, 1'b0);
    wr(8'h00, 32'h0000_1403);
    for (int i = 0; i < 50 && o_nvm_rd !== 1'b1; i++) @(posedge i_ref_clk);
    for (int i = 0; i < 50 && o_nvm_rd === 1'b1; i++) @(posedge i_ref_clk);
    wait_run();
    for (int i = 0; i < 17; i++) rm[i] = nvm.mem[160 + i];
    rdc(8'h01, rm[1]);
    chk(o_profile, 4'h5);
    boot(1'b0, 3'h6);
    wait_run();
    run(60, 1'b0);
    boot(1'b1, 3'h7);
    wait_run();
    run(60, 1'b0);
    wr(8'h0b, 32'h0000_03ff);
    k = nvm.n_rd;
    wr(8'h00, 32'h0000_0007);
    wait_run();
    chk(nvm.n_rd - k, 0);
    rdc(8'h0b, 32'h0000_03ff);
    run(200, 1'b1);
    conclude();
  end
endmodule
